// File: hdl/rms_fifo.sv
`timescale 1ns/1ns
module rms_fifo #(
    parameter int DEPTH = rms_pkg::DEPTH_DEF,
    parameter logic [rms_pkg::SYM_W-1:0] CTRL1 = rms_pkg::CTRL1_SYM,
    parameter logic [rms_pkg::SYM_W-1:0] SKIP1 = rms_pkg::SKIP1_SYM,
    parameter logic [rms_pkg::SYM_W-1:0] CTRL2 = rms_pkg::CTRL2_SYM,
    parameter logic [rms_pkg::SYM_W-1:0] SKIP2 = rms_pkg::SKIP2_SYM
) (
    input wire logic clk, // local reference clock
    input wire logic rst_n, // async reset, both domains
    input wire logic rec_clk, // recovered clock of the lane
    input wire rms_pkg::rms_sym_t rx_in, // aligned symbols, rec_clk
    input wire logic lane_sync, // aligner lock, rec_clk
    input wire logic match_en, // rate matching enable, clk
    input wire logic enc_en, // 8b10b coding enabled, clk
    input wire logic level_raw, // analog threshold comparator
    output rms_pkg::rms_sym_t rx_out, // compensated stream, clk
    output logic ins_pulse, // one skip repeated
    output logic del_pulse, // one skip dropped
    output logic ovf_pulse, // symbol lost, fifo full
    output logic unf_flag, // nothing to read this cycle
    output logic level_ok // signal level detected
);
    localparam int AW = $clog2(DEPTH);
    localparam int PW = AW + 1;
    // margins leave room for one change per cluster either way
    localparam logic [PW-1:0] HI_FILL = PW'(DEPTH - rms_pkg::FILL_MARGIN);
    localparam logic [PW-1:0] LO_FILL = PW'(rms_pkg::FILL_MARGIN);
    localparam logic [PW-1:0] FULL_FILL = PW'(DEPTH);
    localparam logic [PW-1:0] PTR_ONE = PW'(1);

    function automatic logic [PW-1:0] to_gray(input logic [PW-1:0] b);
        to_gray = b ^ (b >> 1);
    endfunction

    function automatic logic [PW-1:0] to_bin(input logic [PW-1:0] g);
        logic [PW-1:0] b;
        b = g;
        for (int i = PW - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        to_bin = b;
    endfunction

    rms_pkg::rms_entry_t mem [DEPTH];

    // ---------------- recovered-clock side ----------------
    logic wrst_s1_reg;
    logic wrst_n_reg;
    logic en_w1_reg;
    logic en_w2_reg;
    logic [PW-1:0] wbin_reg;
    logic [PW-1:0] wbin_next;
    logic [PW-1:0] wgray_reg;
    logic [PW-1:0] rgray_reg;
    logic [PW-1:0] rg_w1_reg;
    logic [PW-1:0] rg_w2_reg;
    logic [rms_pkg::EV_N-1:0] ev_tgl_reg;
    logic [rms_pkg::EV_N-1:0] ev_tgl_next;
    rms_pkg::rms_clu_t clu_reg;
    rms_pkg::rms_clu_t clu_next;

    // reset release retimed onto the recovered clock
    always_ff @(posedge rec_clk or negedge rst_n) begin
        if (!rst_n) begin
            wrst_s1_reg <= 1'b0;
            wrst_n_reg <= 1'b0;
        end else begin
            wrst_s1_reg <= 1'b1;
            wrst_n_reg <= wrst_s1_reg;
        end
    end

    wire is_c1 = rx_in.sym == CTRL1;
    wire is_c2 = rx_in.sym == CTRL2;
    wire is_s1 = rx_in.sym == SKIP1;
    wire is_s2 = rx_in.sym == SKIP2;
    wire w_act = en_w2_reg && lane_sync;
    wire [PW-1:0] wfill = wbin_reg - to_bin(rg_w2_reg);
    wire w_full = wfill == FULL_FILL;
    // skip that directly follows its own control, first in cluster
    wire cand = rx_in.valid &&
        ((clu_reg == rms_pkg::RMS_C1 && is_s1) ||
         (clu_reg == rms_pkg::RMS_C2 && is_s2));
    wire do_del = w_act && cand && wfill >= HI_FILL;
    wire do_wr = lane_sync && rx_in.valid && !do_del && !w_full;
    wire drop = lane_sync && rx_in.valid && !do_del && w_full;

    always_comb begin
        clu_next = clu_reg;
        if (!lane_sync) begin
            clu_next = rms_pkg::RMS_OUT;
        end else if (rx_in.valid) begin
            if (cand) begin
                clu_next = rms_pkg::RMS_USED;
            end else if (is_c1 || is_c2) begin
                if (clu_reg != rms_pkg::RMS_USED) begin
                    clu_next = is_c1 ? rms_pkg::RMS_C1 : rms_pkg::RMS_C2;
                end
            end else if (is_s1 || is_s2) begin
                if (clu_reg != rms_pkg::RMS_USED) begin
                    clu_next = rms_pkg::RMS_OUT;
                end
            end else begin
                clu_next = rms_pkg::RMS_OUT;
            end
        end
    end

    always_comb begin
        wbin_next = wbin_reg;
        if (!lane_sync) begin
            wbin_next = '0;
        end else if (do_wr) begin
            wbin_next = wbin_reg + PTR_ONE;
        end
    end

    always_comb begin
        ev_tgl_next = ev_tgl_reg;
        ev_tgl_next[rms_pkg::EV_DEL] = ev_tgl_reg[rms_pkg::EV_DEL] ^ do_del;
        ev_tgl_next[rms_pkg::EV_OVF] = ev_tgl_reg[rms_pkg::EV_OVF] ^ drop;
    end

    always_ff @(posedge rec_clk or negedge wrst_n_reg) begin
        if (!wrst_n_reg) begin
            en_w1_reg <= 1'b0;
            en_w2_reg <= 1'b0;
        end else begin
            en_w1_reg <= match_en;
            en_w2_reg <= en_w1_reg;
        end
    end

    always_ff @(posedge rec_clk or negedge wrst_n_reg) begin
        if (!wrst_n_reg) begin
            rg_w1_reg <= '0;
            rg_w2_reg <= '0;
        end else begin
            rg_w1_reg <= rgray_reg;
            rg_w2_reg <= rg_w1_reg;
        end
    end

    always_ff @(posedge rec_clk or negedge wrst_n_reg) begin
        if (!wrst_n_reg) begin
            wbin_reg <= '0;
            wgray_reg <= '0;
        end else begin
            wbin_reg <= wbin_next;
            wgray_reg <= to_gray(wbin_next);
        end
    end

    // events faster than the local clock fold by parity: an even count gives no pulse
    always_ff @(posedge rec_clk or negedge wrst_n_reg) begin
        if (!wrst_n_reg) begin
            ev_tgl_reg <= '0;
            clu_reg <= rms_pkg::RMS_OUT;
        end else begin
            ev_tgl_reg <= ev_tgl_next;
            clu_reg <= clu_next;
        end
    end

    // storage has no reset; the tag is only read once written
    always_ff @(posedge rec_clk) begin
        if (do_wr) begin
            mem[wbin_reg[AW-1:0]] <= '{skip_tag: w_act && cand,
                                      sym: rx_in.sym};
        end
    end

    // ---------------- local-clock side ----------------
    logic sy_r1_reg;
    logic sy_r2_reg;
    logic lv_r1_reg;
    logic lv_r2_reg;
    logic [PW-1:0] wg_r1_reg;
    logic [PW-1:0] wg_r2_reg;
    logic [PW-1:0] rbin_reg;
    logic [PW-1:0] rbin_next;
    logic ins_done_reg;
    logic ins_done_next;
    logic [rms_pkg::EV_N-1:0] ev_s1_reg;
    logic [rms_pkg::EV_N-1:0] ev_s2_reg;
    logic [rms_pkg::EV_N-1:0] ev_s3_reg;
    logic [rms_pkg::EV_N-1:0] ev_hit;

    // read side follows the synchronised lock, so it flushes too
    wire r_run = sy_r2_reg;
    wire r_empty = rgray_reg == wg_r2_reg;
    wire [PW-1:0] rfill = to_bin(wg_r2_reg) - rbin_reg;
    rms_pkg::rms_entry_t head;
    assign head = mem[rbin_reg[AW-1:0]];
    // repeat a tagged skip once while the fifo runs low
    wire do_ins = r_run && match_en && sy_r2_reg && !r_empty &&
        head.skip_tag && !ins_done_reg && rfill <= LO_FILL;
    wire pop = r_run && !r_empty && !do_ins;

    always_comb begin
        rbin_next = rbin_reg;
        if (!r_run) begin
            rbin_next = '0;
        end else if (pop) begin
            rbin_next = rbin_reg + PTR_ONE;
        end
    end

    always_comb begin
        ins_done_next = ins_done_reg;
        if (!r_run || pop) begin
            ins_done_next = 1'b0;
        end else if (do_ins) begin
            ins_done_next = 1'b1;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < rms_pkg::EV_N; gi++) begin : g_ev
            assign ev_hit[gi] = ev_s3_reg[gi] ^ ev_s2_reg[gi];
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sy_r1_reg <= 1'b0;
            sy_r2_reg <= 1'b0;
        end else begin
            sy_r1_reg <= lane_sync;
            sy_r2_reg <= sy_r1_reg;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lv_r1_reg <= 1'b0;
            lv_r2_reg <= 1'b0;
        end else begin
            lv_r1_reg <= level_raw;
            lv_r2_reg <= lv_r1_reg;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wg_r1_reg <= '0;
            wg_r2_reg <= '0;
        end else begin
            wg_r1_reg <= wgray_reg;
            wg_r2_reg <= wg_r1_reg;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ev_s1_reg <= '0;
            ev_s2_reg <= '0;
            ev_s3_reg <= '0;
        end else begin
            ev_s1_reg <= ev_tgl_reg;
            ev_s2_reg <= ev_s1_reg;
            ev_s3_reg <= ev_s2_reg;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rbin_reg <= '0;
            rgray_reg <= '0;
            ins_done_reg <= 1'b0;
        end else begin
            rbin_reg <= rbin_next;
            rgray_reg <= to_gray(rbin_next);
            ins_done_reg <= ins_done_next;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_out <= '0;
            unf_flag <= 1'b0;
        end else begin
            rx_out <= '{valid: r_run && !r_empty, sym: head.sym};
            unf_flag <= r_run && r_empty;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ins_pulse <= 1'b0;
            del_pulse <= 1'b0;
            ovf_pulse <= 1'b0;
            level_ok <= 1'b1;
        end else begin
            ins_pulse <= do_ins;
            del_pulse <= ev_hit[rms_pkg::EV_DEL];
            ovf_pulse <= ev_hit[rms_pkg::EV_OVF];
            level_ok <= enc_en ? lv_r2_reg : 1'b1;
        end
    end
endmodule

// File: hdl/rms_pkg.sv
// Notes on behaviour
// - absorb up to 100 ppm each, 200 total
// - optional; default K28.5/K29.7 patterns, both disparities
// - insert/delete only after lane synchronized
// - control then matching skip: insert or delete
// - at most one skip changed per cluster
// - level flag needs 8b10b, else forced high
package rms_pkg;
    localparam int SYM_W = 10;
    // offset budget; depth and margin are sized for it
    localparam int PPM_EACH = 100;
    localparam int PPM_TOTAL = 2 * PPM_EACH;
    // 10-bit code groups, abcdei fghj order, bit 9 first
    localparam logic [SYM_W-1:0] CTRL1_SYM = 10'h305; // K28.5 rd+
    localparam logic [SYM_W-1:0] SKIP1_SYM = 10'h117; // K29.7 rd+
    localparam logic [SYM_W-1:0] CTRL2_SYM = 10'h0fa; // K28.5 rd-
    localparam logic [SYM_W-1:0] SKIP2_SYM = 10'h2e8; // K29.7 rd-
    localparam int DEPTH_DEF = 16;
    localparam int FILL_MARGIN = 4;
    localparam int EV_DEL = 0;
    localparam int EV_OVF = 1;
    localparam int EV_N = 2;

    typedef struct packed {
        logic skip_tag;
        logic [SYM_W-1:0] sym;
    } rms_entry_t;

    typedef struct packed {
        logic valid;
        logic [SYM_W-1:0] sym;
    } rms_sym_t;

    typedef enum logic [1:0] {
        RMS_OUT,
        RMS_C1,
        RMS_C2,
        RMS_USED
    } rms_clu_t;
endpackage

// File: testbench/rms_assertions.sv
`timescale 1ns/1ns
module rms_assertions (
    input wire logic clk, // clock
    input wire logic rst_n, // reset
    input wire logic lane_sync, // lock
    input wire logic match_en, // matching on
    input wire logic enc_en, // coding on
    input wire logic level_raw, // comparator
    input wire rms_pkg::rms_sym_t rx_out, // output
    input wire logic ins_pulse, // inserted
    input wire logic del_pulse, // deleted
    input wire logic ovf_pulse, // overflow
    input wire logic unf_flag, // empty
    input wire logic level_ok // level
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    wire skip_out = rx_out.sym == rms_pkg::SKIP1_SYM ||
        rx_out.sym == rms_pkg::SKIP2_SYM;
    level_forced_a: assert property (!enc_en |=> level_ok)
        else $error("level flag low");
    ins_skip_a: assert property (ins_pulse |-> rx_out.valid && skip_out)
        else $error("insert not on skip");
    ins_repeat_a: assert property (ins_pulse |=> $stable(rx_out))
        else $error("skip not repeated");
    one_change_a: assert property (ins_pulse |=> !ins_pulse[*2])
        else $error("two inserts in cluster");
    ins_gated_a: assert property (!match_en[*3] |-> !ins_pulse)
        else $error("insert while disabled");
    del_gated_a: assert property (!match_en[*8] |-> !del_pulse)
        else $error("delete while disabled");
    unsynced_a: assert property (
        !lane_sync[*8] |-> !rx_out.valid && !del_pulse && !unf_flag)
        else $error("activity without lock");
    ovf_full_a: assert property (ovf_pulse |-> !unf_flag)
        else $error("overflow while empty");
    ins_seen_c: cover property (ins_pulse);
    del_seen_c: cover property (del_pulse);
    ovf_seen_c: cover property (ovf_pulse);
endmodule
bind rms_fifo rms_assertions chk (.clk(clk), .rst_n(rst_n),
    .lane_sync(lane_sync), .match_en(match_en), .enc_en(enc_en),
    .level_raw(level_raw), .rx_out(rx_out), .ins_pulse(ins_pulse),
    .del_pulse(del_pulse), .ovf_pulse(ovf_pulse), .unf_flag(unf_flag),
    .level_ok(level_ok));

// File: testbench/rms_up_tx.sv
`timescale 1ns/1ns
module rms_up_tx (
    input wire logic rec_clk, // lane clock
    input wire logic sync_on, // lock wanted
    input wire logic [2:0] gap, // cycles a symbol, 0 idles
    output rms_pkg::rms_sym_t rx_in, // symbol
    output logic lane_sync // lock
);
    int cnt = 0;
    int pos = 0;
    bit neg = 1'b0;
    initial rx_in = '0;
    initial lane_sync = 1'b0;
    always @(negedge rec_clk) begin
        lane_sync <= sync_on;
        cnt = cnt + 1;
        // gap 3 or 4 keeps the offset small; gap 1 breaks it on purpose
        if (gap == 0 || cnt < gap) begin
            rx_in <= {1'b0, 10'($urandom)};
        end else begin
            cnt = 0;
            rx_in.valid <= 1'b1;
            if (pos > 3)
                rx_in.sym <= {3'h4, 7'($urandom)};
            else if (pos[0])
                rx_in.sym <= neg ? rms_pkg::SKIP2_SYM : rms_pkg::SKIP1_SYM;
            else
                rx_in.sym <= neg ? rms_pkg::CTRL2_SYM : rms_pkg::CTRL1_SYM;
            neg = pos == 7 ? !neg : neg;
            pos = (pos + 1) % 8;
        end
    end
endmodule

// File: testbench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    logic clk = 1'b0, rec_clk = 1'b0, rst_n = 1'b0, sync_on = 1'b0;
    logic match_en = 1'b0, enc_en = 1'b0, level_raw = 1'b0;
    logic [2:0] gap = 3'h0;
    logic lane_sync, ins_pulse, del_pulse, ovf_pulse, unf_flag, level_ok;
    rms_pkg::rms_sym_t rx_in, rx_out;
    int n_mismatch = 0, n_tests = 0, n_ins = 0, n_del = 0, n_ovf = 0;
    int n_drop = 0;
    bit model_on = 1'b0, was_ins = 1'b0, fresh = 1'b1;
    logic [9:0] q[$];
    logic [9:0] last, want;
    initial forever #50 clk = ~clk;
    initial begin
        #7;
        forever #15 rec_clk = ~rec_clk;
    end
    rms_up_tx up (.rec_clk(rec_clk), .sync_on(sync_on), .gap(gap),
        .rx_in(rx_in), .lane_sync(lane_sync));
    rms_fifo dut (.clk(clk), .rst_n(rst_n), .rec_clk(rec_clk),
        .rx_in(rx_in), .lane_sync(lane_sync), .match_en(match_en),
        .enc_en(enc_en), .level_raw(level_raw), .rx_out(rx_out),
        .ins_pulse(ins_pulse), .del_pulse(del_pulse),
        .ovf_pulse(ovf_pulse), .unf_flag(unf_flag), .level_ok(level_ok));
    function automatic bit is_skip(logic [9:0] s);
        return s === rms_pkg::SKIP1_SYM || s === rms_pkg::SKIP2_SYM;
    endfunction
    task automatic check(logic [9:0] seen, logic [9:0] exp_v);
        n_tests++;
        if (seen !== exp_v) begin
            n_mismatch++;
            $display("mismatch at %0t seen %h want %h", $time, seen, exp_v);
        end
    endtask
    task automatic end_of_test();
        $display("%0d compares, %0d mismatches", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic run(bit s, bit m, logic [2:0] g, int n);
        sync_on = s;
        match_en = m;
        gap = g;
        repeat (n) @(negedge clk);
    endtask
    always @(posedge rec_clk)
        if (model_on && rx_in.valid && lane_sync)
            q.push_back(rx_in.sym);
    // a skip may vanish only once, and only in an unused cluster
    always @(negedge clk) begin
        if (model_on && rx_out.valid && was_ins) begin
            check(rx_out.sym, last);
        end else if (model_on && rx_out.valid) begin
            if (q.size() > 1 && q[0] !== rx_out.sym && is_skip(q[0])
                && fresh) begin
                void'(q.pop_front());
                n_drop++;
                fresh = 1'b0;
            end
            want = q.size() > 0 ? q.pop_front() : 10'h3ff;
            check(rx_out.sym, want);
            if (ins_pulse)
                check(10'(fresh), 10'h1);
            fresh = want[9:7] == 3'h4 || fresh && !is_skip(want);
        end
        if (model_on) begin
            n_ins += ins_pulse;
            n_del += del_pulse;
        end
        n_ovf += ovf_pulse;
        was_ins = ins_pulse;
        last = rx_out.sym;
    end
    initial begin
        void'($urandom(87854));
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        repeat (6) begin
            enc_en = 1'($urandom);
            level_raw = 1'($urandom);
            repeat (4) @(negedge clk);
            check(10'(level_ok), 10'(level_raw | !enc_en));
        end
        $display("level test done");
        run(0, 1, 3, 40);
        check(10'(rx_out.valid), 10'h0);
        model_on = 1'b1;
        run(1, 1, 4, 300);
        run(1, 1, 3, 400);
        run(1, 1, 0, 60);
        // a skip dropped as the last symbol has no successor to reveal it
        if (q.size() == 1 && is_skip(q[0]) && fresh) begin
            void'(q.pop_front());
            n_drop++;
        end
        check(10'(q.size()), 10'h0);
        check(10'(unf_flag), 10'h1);
        check(10'(n_drop), 10'(n_del));
        check(10'(n_ins > 0 && n_drop > 0 && n_ovf == 0), 10'h1);
        model_on = 1'b0;
        $display("matching test done");
        run(1, 0, 1, 100);
        check(10'(n_ovf > 0), 10'h1);
        run(0, 0, 0, 20);
        q.delete();
        fresh = 1'b1;
        model_on = 1'b1;
        run(1, 1, 4, 200);
        run(1, 1, 0, 60);
        check(10'(q.size()), 10'h0);
        $display("resync test done");
        end_of_test();
    end
    initial begin
        #300000;
        n_mismatch++;
        end_of_test();
    end
endmodule
